/* File: src/fra_pkg.sv */
// Constants, register map and types for the file register ALU block
package fra_pkg;
    // Register byte offsets
    localparam logic [7:0] REG_INSN = 8'h00;
    localparam logic [7:0] REG_ACC = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
    localparam logic [7:0] REG_PTR0 = 8'h0C;
    localparam logic [7:0] REG_PTR1 = 8'h10;
    localparam logic [7:0] REG_MADR = 8'h14;
    localparam logic [7:0] REG_MDAT = 8'h18;
    // Instruction word fields
    localparam int INSN_OP_LSB = 0;
    localparam int INSN_FADR_LSB = 4;
    localparam int INSN_DEST_BIT = 11;
    localparam int INSN_PIDX_BIT = 12;
    localparam int INSN_UPD_LSB = 13;
    localparam int INSN_REL_BIT = 15;
    localparam int INSN_OFF_LSB = 16;
    // Status bits
    localparam int STAT_C_BIT = 0;
    localparam int STAT_Z_BIT = 2;
    // Data memory and windows
    localparam int DMEM_DEPTH = 128;
    localparam logic [6:0] WIN0_ADDR = 7'h00;
    localparam logic [6:0] WIN1_ADDR = 7'h01;
    // Pointer update types
    localparam logic [1:0] UPD_PRE_INC = 2'h0;
    localparam logic [1:0] UPD_PRE_DEC = 2'h1;
    localparam logic [1:0] UPD_POST_INC = 2'h2;
    localparam logic [1:0] UPD_POST_DEC = 2'h3;
    // Reset values and bus answers
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [15:0] PTR_RST = 16'h0000;
    localparam logic [31:0] INSN_RST = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        OP_NOP, OP_INC, OP_IOR, OP_LSL, OP_LSR, OP_MOV, OP_LDI
    } fra_op_e;
endpackage

/* File: src/fra_alu.sv */
// Byte ALU for the file register operations
`timescale 1ns/1ps
module fra_alu (
    // Operation
    input fra_pkg::fra_op_e op,
    // Operands
    input logic [7:0] opnd,
    input logic [7:0] acc,
    input logic carry_in,
    // Results
    output logic [7:0] result,
    output logic carry_out,
    output logic zero
);
    always_comb begin
        result = opnd;
        carry_out = carry_in;
        case (op)
            fra_pkg::OP_INC: result = opnd + 8'h01;
            fra_pkg::OP_IOR: result = acc | opnd;
            fra_pkg::OP_LSL: begin
                result = {opnd[6:0], 1'b0};
                carry_out = opnd[7];
            end
            fra_pkg::OP_LSR: begin
                result = {1'b0, opnd[7:1]};
                carry_out = opnd[0];
            end
            default: result = opnd;
        endcase
    end

    assign zero = (result == 8'h00);
endmodule

/* File: src/fra_ptr.sv */
// Pointer address and update unit for indirect loads
`timescale 1ns/1ps
module fra_ptr (
    // Pointer and mode
    input logic [15:0] ptr,
    input logic [1:0] upd,
    input logic rel,
    input logic [5:0] off,
    // Results
    output logic [15:0] eff_addr,
    output logic [15:0] ptr_next
);
    logic [15:0] ptr_inc;
    logic [15:0] ptr_dec;

    assign ptr_inc = ptr + 16'h0001;
    assign ptr_dec = ptr - 16'h0001;

    always_comb begin
        eff_addr = ptr;
        ptr_next = ptr;
        if (rel) begin
            eff_addr = ptr + {{10{off[5]}}, off};
        end else begin
            case (upd)
                fra_pkg::UPD_PRE_INC: begin
                    eff_addr = ptr_inc;
                    ptr_next = ptr_inc;
                end
                fra_pkg::UPD_PRE_DEC: begin
                    eff_addr = ptr_dec;
                    ptr_next = ptr_dec;
                end
                fra_pkg::UPD_POST_INC: ptr_next = ptr_inc;
                fra_pkg::UPD_POST_DEC: ptr_next = ptr_dec;
                default: ptr_next = ptr;
            endcase
        end
    end
endmodule

/* File: src/fra_core.sv */
// File register ALU with data memory, pointers and AXI4-Lite access
`timescale 1ns/1ps
// Summary of operation
// - Increment adds one to operand, stores to target, updates zero flag.
// - Target bit zero writes accumulator, one writes operand register back.
// - OR combines accumulator and operand bitwise, stores to target, sets zero.
// - Left shift puts bit 7 in carry, zero enters bit 0.
// - Right shift puts bit 0 in carry, zero enters bit 7.
// - Move copies operand to target and updates zero flag.
// - Indirect load reads pointer-addressed byte into accumulator; index picks pointer.
// - Pre forms use pointer plus or minus one and keep it.
// - Post forms use current pointer, then increment or decrement it.
// - Relative form adds signed offset -32..31; pointer stays unchanged.
// - File operations on window addresses do not use bytes 0 and 1; they reach the pointed byte.
// - Pointers are 16 bits and wrap on overflow and underflow.
// - Pointer updates never touch status flags; only data sets zero.
module fra_core (
    // Clock and reset
    input logic aclk,
    input logic aresetn,
    // Write address
    input logic [7:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    output logic s_axi_awready,
    // Write data
    input logic [31:0] s_axi_wdata,
    input logic [3:0] s_axi_wstrb,
    input logic s_axi_wvalid,
    output logic s_axi_wready,
    // Write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input logic s_axi_bready,
    // Read address
    input logic [7:0] s_axi_araddr,
    input logic s_axi_arvalid,
    output logic s_axi_arready,
    // Read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input logic s_axi_rready
);
    logic aw_got_q, aw_got_d, w_got_q, w_got_d;
    logic [7:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
    logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d, insn_q, insn_d;
    logic [7:0] acc_q, acc_d;
    logic c_q, c_d, z_q, z_d;
    logic [15:0] ptr_q [2];
    logic [15:0] ptr_d [2];
    logic [6:0] madr_q, madr_d;
    logic [7:0] mem_q [fra_pkg::DMEM_DEPTH];
    logic mem_we;
    logic [6:0] mem_wa;
    logic [7:0] mem_wd;
    logic wr_go, exec;
    logic [31:0] insn_new, wmrg;
    fra_pkg::fra_op_e op;
    logic [6:0] faddr, idx;
    logic dest, pidx;
    logic [15:0] pea, pnext;
    logic [7:0] opnd, alu_res;
    logic alu_c, alu_z;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                m[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return m;
    endfunction

    function automatic logic hit(input logic [7:0] a);
        logic [7:0] w;
        w = {a[7:2], 2'b00};
        return w == fra_pkg::REG_INSN || w == fra_pkg::REG_ACC || w == fra_pkg::REG_STAT
            || w == fra_pkg::REG_PTR0 || w == fra_pkg::REG_PTR1
            || w == fra_pkg::REG_MADR || w == fra_pkg::REG_MDAT;
    endfunction

    function automatic logic [31:0] rd(input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        case ({a[7:2], 2'b00})
            fra_pkg::REG_INSN: v = insn_q;
            fra_pkg::REG_ACC: v[7:0] = acc_q;
            fra_pkg::REG_STAT: begin
                v[fra_pkg::STAT_C_BIT] = c_q;
                v[fra_pkg::STAT_Z_BIT] = z_q;
            end
            fra_pkg::REG_PTR0: v[15:0] = ptr_q[0];
            fra_pkg::REG_PTR1: v[15:0] = ptr_q[1];
            fra_pkg::REG_MADR: v[6:0] = madr_q;
            fra_pkg::REG_MDAT: v[7:0] = mem_q[madr_q];
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    // Write fires once address and data are both held
    assign wr_go = aw_got_q & w_got_q & ~bvalid_q;
    assign exec = wr_go & ({awaddr_q[7:2], 2'b00} == fra_pkg::REG_INSN);
    // A process, not an assign, so register changes behind the call are seen
    always_comb begin
        wmrg = merge(rd(awaddr_q), wdata_q, wstrb_q);
    end
    assign insn_new = wmrg;

    assign op = fra_pkg::fra_op_e'(insn_new[fra_pkg::INSN_OP_LSB +: 3]);
    assign faddr = insn_new[fra_pkg::INSN_FADR_LSB +: 7];
    assign dest = insn_new[fra_pkg::INSN_DEST_BIT];
    assign pidx = insn_new[fra_pkg::INSN_PIDX_BIT];

    fra_ptr u_ptr (
        .ptr(ptr_q[pidx]),
        .upd(insn_new[fra_pkg::INSN_UPD_LSB +: 2]),
        .rel(insn_new[fra_pkg::INSN_REL_BIT]),
        .off(insn_new[fra_pkg::INSN_OFF_LSB +: 6]),
        .eff_addr(pea),
        .ptr_next(pnext)
    );

    // windows redirect to pointed byte
    // Memory covers only the low seven address bits of a pointer
    always_comb begin
        if (op == fra_pkg::OP_LDI) begin
            idx = pea[6:0];
        end else if (faddr == fra_pkg::WIN0_ADDR) begin
            idx = ptr_q[0][6:0];
        end else if (faddr == fra_pkg::WIN1_ADDR) begin
            idx = ptr_q[1][6:0];
        end else begin
            idx = faddr;
        end
    end
    assign opnd = mem_q[idx];

    fra_alu u_alu (
        .op(op),
        .opnd(opnd),
        .acc(acc_q),
        .carry_in(c_q),
        .result(alu_res),
        .carry_out(alu_c),
        .zero(alu_z)
    );

    always_comb begin
        aw_got_d = aw_got_q;
        awaddr_d = awaddr_q;
        w_got_d = w_got_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        insn_d = insn_q;
        acc_d = acc_q;
        c_d = c_q;
        z_d = z_q;
        ptr_d = ptr_q;
        madr_d = madr_q;
        mem_we = 1'b0;
        mem_wa = madr_q;
        mem_wd = wmrg[7:0];
        if (s_axi_awvalid && awready_q) begin
            aw_got_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q) begin
            w_got_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (wr_go) begin
            aw_got_d = 1'b0;
            w_got_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = hit(awaddr_q) ? fra_pkg::RESP_OKAY : fra_pkg::RESP_SLVERR;
            case ({awaddr_q[7:2], 2'b00})
                fra_pkg::REG_INSN: begin
                    insn_d = insn_new;
                    if (op == fra_pkg::OP_LDI) begin
                        acc_d = alu_res;
                        z_d = alu_z;
                        ptr_d[pidx] = pnext;
                    end else if (op != fra_pkg::OP_NOP) begin
                        if (dest) begin
                            mem_we = 1'b1;
                            mem_wa = idx;
                            mem_wd = alu_res;
                        end else begin
                            acc_d = alu_res;
                        end
                        z_d = alu_z;
                        c_d = alu_c;
                    end
                end
                fra_pkg::REG_ACC: acc_d = wmrg[7:0];
                fra_pkg::REG_STAT: begin
                    c_d = wmrg[fra_pkg::STAT_C_BIT];
                    z_d = wmrg[fra_pkg::STAT_Z_BIT];
                end
                fra_pkg::REG_PTR0: ptr_d[0] = wmrg[15:0];
                fra_pkg::REG_PTR1: ptr_d[1] = wmrg[15:0];
                fra_pkg::REG_MADR: madr_d = wmrg[6:0];
                fra_pkg::REG_MDAT: mem_we = 1'b1;
                default: mem_we = 1'b0;
            endcase
        end
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rdata_d = rd(s_axi_araddr);
            rresp_d = hit(s_axi_araddr) ? fra_pkg::RESP_OKAY : fra_pkg::RESP_SLVERR;
        end
        // One write and one read in flight at most
        awready_d = ~aw_got_d & ~bvalid_d;
        wready_d = ~w_got_d & ~bvalid_d;
        arready_d = ~rvalid_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            arready_q <= 1'b0;
            bvalid_q <= 1'b0;
            rvalid_q <= 1'b0;
            bresp_q <= fra_pkg::RESP_OKAY;
            rresp_q <= fra_pkg::RESP_OKAY;
            rdata_q <= 32'h0000_0000;
            insn_q <= fra_pkg::INSN_RST;
            acc_q <= fra_pkg::ACC_RST;
            c_q <= 1'b0;
            z_q <= 1'b0;
            ptr_q[0] <= fra_pkg::PTR_RST;
            ptr_q[1] <= fra_pkg::PTR_RST;
            madr_q <= 7'h00;
        end else begin
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            arready_q <= arready_d;
            bvalid_q <= bvalid_d;
            rvalid_q <= rvalid_d;
            bresp_q <= bresp_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            insn_q <= insn_d;
            acc_q <= acc_d;
            c_q <= c_d;
            z_q <= z_d;
            ptr_q <= ptr_d;
            madr_q <= madr_d;
        end
    end

    // Memory is cleared so reads after reset are defined
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < fra_pkg::DMEM_DEPTH; i++) begin
                mem_q[i] <= 8'h00;
            end
        end else if (mem_we) begin
            mem_q[mem_wa] <= mem_wd;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    inc_to_acc_a: assert property (
        exec && op == fra_pkg::OP_INC && !dest |=> acc_q == $past(opnd) + 8'h01)
        else $error("increment result wrong");
    dest_file_a: assert property (
        exec && op != fra_pkg::OP_NOP && op != fra_pkg::OP_LDI && dest
        |=> acc_q == $past(acc_q) && mem_q[$past(idx)] == $past(alu_res))
        else $error("file target not written");
    ior_acc_a: assert property (
        exec && op == fra_pkg::OP_IOR && !dest |=> acc_q == ($past(acc_q) | $past(opnd)))
        else $error("or result wrong");
    lsl_carry_a: assert property (
        exec && op == fra_pkg::OP_LSL |=> c_q == $past(opnd[7]))
        else $error("left shift carry wrong");
    lsr_acc_a: assert property (
        exec && op == fra_pkg::OP_LSR && !dest
        |=> acc_q == {1'b0, $past(opnd[7:1])} && c_q == $past(opnd[0]))
        else $error("right shift wrong");
    zero_flag_a: assert property (
        exec && op != fra_pkg::OP_NOP |=> z_q == ($past(alu_res) == 8'h00))
        else $error("zero flag wrong");
    ptr_wrap_a: assert property (
        exec && op == fra_pkg::OP_LDI && !insn_new[fra_pkg::INSN_REL_BIT]
        && !insn_new[fra_pkg::INSN_UPD_LSB]
        && ptr_q[pidx] == 16'hFFFF |=> ptr_q[$past(pidx)] == 16'h0000)
        else $error("pointer did not wrap");
    rel_hold_a: assert property (
        exec && op == fra_pkg::OP_LDI && insn_new[fra_pkg::INSN_REL_BIT]
        |=> ptr_q[0] == $past(ptr_q[0]) && ptr_q[1] == $past(ptr_q[1]))
        else $error("relative form moved pointer");
    ldi_carry_a: assert property (
        exec && op == fra_pkg::OP_LDI |=> c_q == $past(c_q))
        else $error("indirect load touched carry");
    one_cycle_a: assert property (
        aw_got_q && w_got_q && !bvalid_q |=> bvalid_q ##0 !aw_got_q)
        else $error("operation not single cycle");

    ldi_pre_c: cover property (exec && op == fra_pkg::OP_LDI
        && insn_new[fra_pkg::INSN_UPD_LSB +: 2] == fra_pkg::UPD_PRE_DEC);
    lsl_carry_c: cover property (exec && op == fra_pkg::OP_LSL && opnd[7]);
    window_c: cover property (exec && op == fra_pkg::OP_MOV && faddr == fra_pkg::WIN1_ADDR);
    rd_err_c: cover property (s_axi_rvalid && s_axi_rresp == fra_pkg::RESP_SLVERR);
endmodule

/* File: verification/fra_host_model.sv */
// Register bus master standing in for the instruction decoder side
`timescale 1ns/1ps
module fra_host_model (
    // Clock
    input logic aclk,
    // Write address and data
    output logic [7:0] awaddr,
    output logic awvalid,
    input logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input logic wready,
    // Write response
    input logic [1:0] bresp,
    input logic bvalid,
    output logic bready,
    // Read address and data
    output logic [7:0] araddr,
    output logic arvalid,
    input logic arready,
    input logic [31:0] rdata,
    input logic [1:0] rresp,
    input logic rvalid,
    output logic rready
);
    initial begin
        awaddr = 8'h00;
        awvalid = 1'b0;
        wdata = 32'h0000_0000;
        wstrb = 4'hf;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = 8'h00;
        arvalid = 1'b0;
        rready = 1'b0;
    end

    // Released lines show the inverse so a late sample cannot pass
    task automatic write(input logic [7:0] a, input logic [31:0] d,
            output logic [1:0] r, output bit to);
        to = 1'b1;
        r = 2'h3;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata <= ~d;
            end
            if (bvalid && bready) begin
                r = bresp;
                to = 1'b0;
                break;
            end
        end
        bready <= 1'b0;
    endtask

    task automatic read(input logic [7:0] a, output logic [31:0] d,
            output logic [1:0] r, output bit to);
        to = 1'b1;
        r = 2'h3;
        d = 32'h0000_0000;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr <= ~a;
            end
            if (rvalid && rready) begin
                d = rdata;
                r = rresp;
                to = 1'b0;
                break;
            end
        end
        rready <= 1'b0;
    endtask
endmodule

/* File: verification/fra_core_tb.sv */
// Self-checking bench for the file register ALU block
`timescale 1ns/1ps
module fra_core_tb;
    logic aclk;
    logic aresetn;
    logic [7:0] awaddr;
    logic awvalid;
    logic awready;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready;
    int mismatches = 0;
    int total_checks = 0;
    logic [1:0] last_resp;
    logic [31:0] v;
    logic [7:0] pa;
    localparam logic [31:0] CF = 32'h0000_0001 << fra_pkg::STAT_C_BIT;
    localparam logic [31:0] ZF = 32'h0000_0001 << fra_pkg::STAT_Z_BIT;
    logic [31:0] ldi_acc [4] = '{32'h0000_00a3, 32'h0000_00a1, 32'h0000_00a2, 32'h0000_00a2};
    logic [31:0] ldi_ptr [4] = '{32'h0000_1231, 32'h0000_122f, 32'h0000_1231, 32'h0000_122f};

    fra_core i_dut (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid),
        .s_axi_awready(awready),
        .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid),
        .s_axi_wready(wready),
        .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid),
        .s_axi_bready(bready),
        .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid),
        .s_axi_arready(arready),
        .s_axi_rdata(rdata),
        .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid),
        .s_axi_rready(rready)
    );

    fra_host_model i_host (
        .aclk(aclk),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready)
    );

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic hang(input bit to);
        if (to) begin
            mismatches++;
            give_verdict();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit to;
        i_host.write(a, d, last_resp, to);
        hang(to);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bit to;
        i_host.read(a, v, last_resp, to);
        hang(to);
        chk(v, e);
    endtask

    task automatic setm(input logic [6:0] a, input logic [7:0] d);
        wr(fra_pkg::REG_MADR, {25'h0, a});
        wr(fra_pkg::REG_MDAT, {24'h0, d});
    endtask

    task automatic memc(input logic [6:0] a, input logic [7:0] e);
        wr(fra_pkg::REG_MADR, {25'h0, a});
        rdc(fra_pkg::REG_MDAT, {24'h0, e});
    endtask

    function automatic logic [31:0] insn(input fra_pkg::fra_op_e op, input logic [6:0] f,
            input logic d, input logic p, input logic [1:0] u, input logic r,
            input logic [5:0] o);
        insn = 32'h0000_0000;
        insn[fra_pkg::INSN_OP_LSB +: 3] = op;
        insn[fra_pkg::INSN_FADR_LSB +: 7] = f;
        insn[fra_pkg::INSN_DEST_BIT] = d;
        insn[fra_pkg::INSN_PIDX_BIT] = p;
        insn[fra_pkg::INSN_UPD_LSB +: 2] = u;
        insn[fra_pkg::INSN_REL_BIT] = r;
        insn[fra_pkg::INSN_OFF_LSB +: 6] = o;
    endfunction

    task automatic fop(input fra_pkg::fra_op_e op, input logic [6:0] f, input logic d);
        wr(fra_pkg::REG_INSN, insn(op, f, d, 1'b0, 2'h0, 1'b0, 6'h00));
    endtask

    task automatic ldi(input logic p, input logic [1:0] u, input logic r, input logic [5:0] o);
        wr(fra_pkg::REG_INSN, insn(fra_pkg::OP_LDI, 7'h00, 1'b0, p, u, r, o));
    endtask

    initial begin
        aresetn = 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rdc(fra_pkg::REG_PTR0, 32'h0000_0000);
        rdc(fra_pkg::REG_PTR1, 32'h0000_0000);
        rdc(fra_pkg::REG_STAT, 32'h0000_0000);
        setm(7'h20, 8'h7f);
        fop(fra_pkg::OP_INC, 7'h20, 1'b0);
        rdc(fra_pkg::REG_ACC, 32'h0000_0080);
        memc(7'h20, 8'h7f);
        rdc(fra_pkg::REG_STAT, 32'h0000_0000);
        setm(7'h21, 8'hff);
        fop(fra_pkg::OP_INC, 7'h21, 1'b1);
        memc(7'h21, 8'h00);
        rdc(fra_pkg::REG_ACC, 32'h0000_0080);
        rdc(fra_pkg::REG_STAT, ZF);
        // Z still set from the wrap, so OR must clear it
        wr(fra_pkg::REG_ACC, 32'h0000_0005);
        setm(7'h22, 8'h50);
        fop(fra_pkg::OP_IOR, 7'h22, 1'b1);
        memc(7'h22, 8'h55);
        rdc(fra_pkg::REG_ACC, 32'h0000_0005);
        rdc(fra_pkg::REG_STAT, 32'h0000_0000);
        fop(fra_pkg::OP_IOR, 7'h22, 1'b0);
        rdc(fra_pkg::REG_ACC, 32'h0000_0055);
        setm(7'h7f, 8'h3f);
        fop(fra_pkg::OP_INC, 7'h7f, 1'b1);
        memc(7'h7f, 8'h40);
        setm(7'h23, 8'h81);
        fop(fra_pkg::OP_LSL, 7'h23, 1'b0);
        rdc(fra_pkg::REG_ACC, 32'h0000_0002);
        rdc(fra_pkg::REG_STAT, CF);
        setm(7'h26, 8'h00);
        fop(fra_pkg::OP_MOV, 7'h26, 1'b1);
        rdc(fra_pkg::REG_STAT, CF | ZF);
        fop(fra_pkg::OP_MOV, 7'h23, 1'b0);
        rdc(fra_pkg::REG_ACC, 32'h0000_0081);
        rdc(fra_pkg::REG_STAT, CF);
        setm(7'h24, 8'h01);
        fop(fra_pkg::OP_LSR, 7'h24, 1'b1);
        memc(7'h24, 8'h00);
        rdc(fra_pkg::REG_STAT, CF | ZF);
        setm(7'h25, 8'h80);
        fop(fra_pkg::OP_LSR, 7'h25, 1'b0);
        rdc(fra_pkg::REG_ACC, 32'h0000_0040);
        rdc(fra_pkg::REG_STAT, 32'h0000_0000);
        setm(7'h2f, 8'ha1);
        setm(7'h30, 8'ha2);
        setm(7'h31, 8'ha3);
        // Carry set up front so a pointer step that touches flags shows
        wr(fra_pkg::REG_STAT, CF);
        for (int u = 0; u < 4; u++) begin
            pa = u[0] ? fra_pkg::REG_PTR1 : fra_pkg::REG_PTR0;
            wr(pa, 32'h0000_1230);
            ldi(u[0], 2'(u), 1'b0, 6'h00);
            rdc(fra_pkg::REG_ACC, ldi_acc[u]);
            rdc(pa, ldi_ptr[u]);
            rdc(fra_pkg::REG_STAT, CF);
        end
        setm(7'h00, 8'h00);
        wr(fra_pkg::REG_PTR1, 32'h0000_ffff);
        ldi(1'b1, fra_pkg::UPD_PRE_INC, 1'b0, 6'h00);
        rdc(fra_pkg::REG_PTR1, 32'h0000_0000);
        rdc(fra_pkg::REG_ACC, 32'h0000_0000);
        rdc(fra_pkg::REG_STAT, CF | ZF);
        wr(fra_pkg::REG_PTR0, 32'h0000_0000);
        ldi(1'b0, fra_pkg::UPD_POST_DEC, 1'b0, 6'h00);
        rdc(fra_pkg::REG_PTR0, 32'h0000_ffff);
        wr(fra_pkg::REG_PTR0, 32'h0000_0040);
        setm(7'h5f, 8'h9e);
        ldi(1'b0, fra_pkg::UPD_PRE_INC, 1'b1, 6'h1f);
        rdc(fra_pkg::REG_ACC, 32'h0000_009e);
        ldi(1'b0, fra_pkg::UPD_POST_INC, 1'b1, 6'h20);
        rdc(fra_pkg::REG_ACC, 32'h0000_007f);
        rdc(fra_pkg::REG_PTR0, 32'h0000_0040);
        wr(fra_pkg::REG_PTR1, 32'h0000_0060);
        setm(7'h60, 8'h11);
        fop(fra_pkg::OP_INC, fra_pkg::WIN1_ADDR, 1'b1);
        memc(7'h60, 8'h12);
        fop(fra_pkg::OP_MOV, fra_pkg::WIN1_ADDR, 1'b0);
        rdc(fra_pkg::REG_ACC, 32'h0000_0012);
        rdc(fra_pkg::REG_PTR1, 32'h0000_0060);
        wr(8'h40, 32'h0000_00ff);
        chk({30'h0, last_resp}, {30'h0, fra_pkg::RESP_SLVERR});
        rdc(8'h40, 32'h0000_0000);
        chk({30'h0, last_resp}, {30'h0, fra_pkg::RESP_SLVERR});
        give_verdict();
    end
endmodule
